// *** core/uhp_pkg.sv ***
package uhp_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NCH = 4;
	localparam int NTMR = 9;
	localparam int NPTR = 4;
	localparam int NAPP = 4;
	localparam int PAD_DEPTH = 64;
	localparam int PAD_AW = 6;
	localparam int APB_AW = 8;
	localparam int CNT_W = 24;
	localparam int TMR_DLY_W = 24;
	localparam int IRQ_W = 13;
	localparam int ILIM_W = 8;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] A_CMD = 8'h00;
	localparam logic [7:0] A_HUBMODE = 8'h04;
	localparam logic [7:0] A_UPMODE = 8'h08;
	localparam logic [7:0] A_UPSTATE = 8'h0C;
	localparam logic [7:0] A_ERRBANK = 8'h10;
	localparam logic [7:0] A_ERRSTAT = 8'h14;
	localparam logic [7:0] A_ILIMIT = 8'h18;
	localparam logic [7:0] A_IRQSTAT = 8'h1C;
	localparam logic [7:0] A_IRQCLR = 8'h20;
	localparam logic [7:0] A_IRQEN = 8'h24;
	localparam logic [7:0] A_PSTATE = 8'h30;
	localparam logic [7:0] A_TMR = 8'h40;
	localparam logic [7:0] A_PTR = 8'h70;
	localparam logic [7:0] A_PDATA = 8'h80;
	localparam logic [7:0] A_APP = 8'h90;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CMD_CH_LSB = 0;
	localparam int CMD_OP_LSB = 2;
	localparam int HM_STRIDE = 2;
	localparam int HM_DATA = 0;
	localparam int HM_VBUS = 1;
	localparam int PS_VBUS = 0;
	localparam int PS_DATA = 1;
	localparam int PS_ERR = 19;
	localparam int PS_BOOST = 20;
	localparam int ERR_STRIDE = 8;
	localparam int ERR_OC = 0;
	localparam int ERR_BD = 1;
	localparam int ERR_PF = 2;
	localparam int ERR_DC = 3;
	localparam int TMR_ONESHOT = 31;
	localparam int TMR_RUN = 30;
	localparam int PTR_FIXED = 8;
	localparam int IRQ_TMR_LSB = 4;
	localparam logic [7:0] ERR_BANK0 = 8'h00;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_KHZ = 40000;
	localparam int unsigned BACKDRIVE_MS = 5;
	localparam int unsigned DISCHARGE_MS = 200;
	localparam int unsigned BACKDRIVE_CYC = BACKDRIVE_MS * CLK_KHZ;
	localparam int unsigned DISCHARGE_CYC = DISCHARGE_MS * CLK_KHZ;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		UP_EDGE = 2'h0,
		UP_MINIB = 2'h1,
		UP_AUTO = 2'h2
	} uhp_upmode_t;

	typedef enum logic [2:0] {
		OP_PWR_ON = 3'h0,
		OP_PWR_OFF = 3'h1,
		OP_DATA_ON = 3'h2,
		OP_DATA_OFF = 3'h3,
		OP_PORT_ON = 3'h4,
		OP_PORT_OFF = 3'h5,
		OP_CLR_ERR = 3'h6
	} uhp_op_t;

	typedef struct packed {
		logic [NCH-1:0] vbusHigh;
		logic [NCH-1:0] vbusLow;
		logic [NCH-1:0] powerFail;
		logic [NCH-1:0] boostOn;
		logic miniBVbus;
	} uhp_pins_t;

endpackage : uhp_pkg

// *** core/uhp_port_ctrl.sv ***
`timescale 1ns/1ps

module uhp_port_ctrl
	import uhp_pkg::*;
#(
	parameter int unsigned BD_CYCLES = BACKDRIVE_CYC,
	parameter int unsigned DC_CYCLES = DISCHARGE_CYC
)
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Port sense pins and current readings.
	input wire uhp_pins_t pins,
	input wire logic [NCH-1:0][ILIM_W-1:0] portCurrent,
	// Port switches.
	output logic [NCH-1:0] vbusEnable,
	output logic [NCH-1:0] dataEnable,
	output logic [NCH-1:0] dischargeOn,
	output logic upstreamMiniB,
	// On-device handlers.
	output logic [NTMR-1:0] timerFire,
	output logic [NAPP-1:0] appTrigger,
	output logic [31:0] appParam,
	input wire logic [NAPP-1:0] appDone,
	input wire logic [31:0] appResult,
	// Interrupt.
	output logic irq
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [NCH-1:0] vbusEn;
		logic [NCH-1:0] dataEn;
		uhp_upmode_t upMode;
		logic upMiniB;
		logic [7:0] errBank;
		logic [NCH-1:0][ILIM_W-1:0] iLimit;
		logic [NCH-1:0][3:0] err;
		logic [NCH-1:0][CNT_W-1:0] bdCnt;
		logic [NCH-1:0][CNT_W-1:0] dcCnt;
		logic [NCH-1:0] dcOn;
		logic [IRQ_W-1:0] irqStat;
		logic [IRQ_W-1:0] irqEn;
		logic irq;
		logic [NTMR-1:0][TMR_DLY_W-1:0] tmrCnt;
		logic [NTMR-1:0][TMR_DLY_W-1:0] tmrLoad;
		logic [NTMR-1:0] tmrOneShot;
		logic [NTMR-1:0] tmrRun;
		logic [NTMR-1:0] tmrFire;
		logic [NPTR-1:0][PAD_AW-1:0] ptrOff;
		logic [NPTR-1:0] ptrFixed;
		logic [PAD_DEPTH-1:0][7:0] pad;
		logic [NAPP-1:0][31:0] appVal;
		logic [NAPP-1:0] appGo;
		logic [31:0] appArg;
		uhp_pins_t sync1;
		uhp_pins_t sync2;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} uhp_state_t;

	localparam logic [CNT_W-1:0] BD_LIM = CNT_W'(BD_CYCLES);
	localparam logic [CNT_W-1:0] DC_LIM = CNT_W'(DC_CYCLES);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
	localparam logic [TMR_DLY_W-1:0] TMR_ONE = TMR_DLY_W'(1);

	uhp_state_t s;
	uhp_state_t next_s;
	logic setup;
	logic wr;
	logic rdAcc;
	logic hit;
	logic [31:0] rd;
	logic [3:0] ix;
	logic [3:0] setErr;
	uhp_op_t op;
	logic [1:0] ch;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// True when an aligned address falls in an array of n words.
	function automatic logic inBlk(input logic [7:0] a,
		input logic [7:0] base, input int n);
		logic [7:0] d;
		d = a - base;
		return (a >= base) && (d[7:2] < 6'(n)) && (a[1:0] == 2'h0);
	endfunction : inBlk

	// Word index of an address within an array.
	function automatic logic [3:0] regIdx(input logic [7:0] a,
		input logic [7:0] base);
		logic [7:0] d;
		d = a - base;
		return d[5:2];
	endfunction : regIdx

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------

	// Computes the whole next state: bus, timers, flags and interrupt.
	always_comb
	begin
		next_s = s;
		rd = '0;
		hit = 1'b0;
		ix = '0;
		setErr = '0;
		op = uhp_op_t'(pwdata[CMD_OP_LSB +: 3]);
		ch = pwdata[CMD_CH_LSB +: 2];
		setup = psel & ~penable;
		wr = psel & penable & s.pready & pwrite;
		rdAcc = psel & penable & s.pready & ~pwrite;

		// Pin synchroniser, second stage only is read.
		next_s.sync1 = pins;
		next_s.sync2 = s.sync1;

		// Read decode in the setup cycle, answer in the first access.
		if (paddr == A_CMD || paddr == A_IRQCLR)
		begin
			hit = 1'b1;
		end
		else if (paddr == A_HUBMODE)
		begin
			hit = 1'b1;
			for (int c = 0; c < NCH; c++)
			begin
				rd[HM_STRIDE*c+HM_DATA] = s.dataEn[c];
				rd[HM_STRIDE*c+HM_VBUS] = s.vbusEn[c];
			end
		end
		else if (paddr == A_UPMODE)
		begin
			hit = 1'b1;
			rd[1:0] = s.upMode;
		end
		else if (paddr == A_UPSTATE)
		begin
			hit = 1'b1;
			rd[0] = s.upMiniB;
		end
		else if (paddr == A_ERRBANK)
		begin
			hit = 1'b1;
			rd[7:0] = s.errBank;
		end
		else if (paddr == A_ERRSTAT)
		begin
			hit = 1'b1;
			if (s.errBank == ERR_BANK0)
			begin
				for (int c = 0; c < NCH; c++)
				begin
					rd[ERR_STRIDE*c +: 4] = s.err[c];
				end
			end
		end
		else if (paddr == A_ILIMIT)
		begin
			hit = 1'b1;
			rd = s.iLimit;
		end
		else if (paddr == A_IRQSTAT)
		begin
			hit = 1'b1;
			rd[IRQ_W-1:0] = s.irqStat;
		end
		else if (paddr == A_IRQEN)
		begin
			hit = 1'b1;
			rd[IRQ_W-1:0] = s.irqEn;
		end
		else if (inBlk(paddr, A_PSTATE, NCH))
		begin
			hit = 1'b1;
			ix = regIdx(paddr, A_PSTATE);
			rd[PS_VBUS] = s.vbusEn[ix[1:0]];
			rd[PS_DATA] = s.dataEn[ix[1:0]];
			rd[PS_ERR] = |s.err[ix[1:0]];
			rd[PS_BOOST] = s.sync2.boostOn[ix[1:0]];
		end
		else if (inBlk(paddr, A_TMR, NTMR))
		begin
			hit = 1'b1;
			ix = regIdx(paddr, A_TMR);
			rd[TMR_DLY_W-1:0] = s.tmrCnt[ix];
			rd[TMR_RUN] = s.tmrRun[ix];
			rd[TMR_ONESHOT] = s.tmrOneShot[ix];
		end
		else if (inBlk(paddr, A_PTR, NPTR))
		begin
			hit = 1'b1;
			ix = regIdx(paddr, A_PTR);
			rd[PAD_AW-1:0] = s.ptrOff[ix[1:0]];
			rd[PTR_FIXED] = s.ptrFixed[ix[1:0]];
		end
		else if (inBlk(paddr, A_PDATA, NPTR))
		begin
			hit = 1'b1;
			ix = regIdx(paddr, A_PDATA);
			rd[7:0] = s.pad[s.ptrOff[ix[1:0]]];
		end
		else if (inBlk(paddr, A_APP, NAPP))
		begin
			hit = 1'b1;
			ix = regIdx(paddr, A_APP);
			rd = s.appVal[ix[1:0]];
		end
		next_s.pready = setup;
		next_s.pslverr = setup & ~hit;
		next_s.prdata = (setup && !pwrite) ? rd : '0;

		next_s.tmrFire = '0;
		for (int t = 0; t < NTMR; t++)
		begin
			if (s.tmrRun[t])
			begin
				if (s.tmrCnt[t] == TMR_ONE)
				begin
					next_s.tmrFire[t] = 1'b1;
					next_s.tmrCnt[t] = s.tmrLoad[t];
					next_s.tmrRun[t] = ~s.tmrOneShot[t];
				end
				else
				begin
					next_s.tmrCnt[t] = s.tmrCnt[t] - TMR_ONE;
				end
			end
		end

		next_s.appGo = '0;
		for (int a = 0; a < NAPP; a++)
		begin
			if (appDone[a])
			begin
				next_s.appVal[a] = appResult;
			end
		end

		// pointer advances after a data read unless it is fixed
		if (rdAcc && inBlk(paddr, A_PDATA, NPTR))
		begin
			ix = regIdx(paddr, A_PDATA);
			if (!s.ptrFixed[ix[1:0]])
			begin
				next_s.ptrOff[ix[1:0]] = s.ptrOff[ix[1:0]] + 1'b1;
			end
		end

		// Register writes; reserved bits are simply not stored.
		// reserved bits dropped
		if (wr)
		begin
			if (paddr == A_CMD)
			begin
				case (op)
					OP_PWR_ON: next_s.vbusEn[ch] = 1'b1;
					OP_PWR_OFF: next_s.vbusEn[ch] = 1'b0;
					OP_DATA_ON: next_s.dataEn[ch] = 1'b1;
					OP_DATA_OFF: next_s.dataEn[ch] = 1'b0;
					OP_PORT_ON:
					begin
						next_s.vbusEn[ch] = 1'b1;
						next_s.dataEn[ch] = 1'b1;
					end
					OP_PORT_OFF:
					begin
						next_s.vbusEn[ch] = 1'b0;
						next_s.dataEn[ch] = 1'b0;
					end
					OP_CLR_ERR: next_s.err[ch] = '0;
					default: next_s.err = s.err;
				endcase
			end
			else if (paddr == A_HUBMODE)
			begin
				for (int c = 0; c < NCH; c++)
				begin
					next_s.dataEn[c] = pwdata[HM_STRIDE*c+HM_DATA];
					next_s.vbusEn[c] = pwdata[HM_STRIDE*c+HM_VBUS];
				end
			end
			else if (paddr == A_UPMODE)
			begin
				if (pwdata[1:0] <= UP_AUTO)
				begin
					next_s.upMode = uhp_upmode_t'(pwdata[1:0]);
				end
			end
			else if (paddr == A_ERRBANK)
			begin
				next_s.errBank = pwdata[7:0];
			end
			else if (paddr == A_ILIMIT)
			begin
				next_s.iLimit = pwdata;
			end
			else if (paddr == A_IRQCLR)
			begin
				next_s.irqStat = s.irqStat & ~pwdata[IRQ_W-1:0];
			end
			else if (paddr == A_IRQEN)
			begin
				next_s.irqEn = pwdata[IRQ_W-1:0];
			end
			else if (inBlk(paddr, A_TMR, NTMR))
			begin
				ix = regIdx(paddr, A_TMR);
				next_s.tmrLoad[ix] = pwdata[TMR_DLY_W-1:0];
				next_s.tmrCnt[ix] = pwdata[TMR_DLY_W-1:0];
				next_s.tmrOneShot[ix] = pwdata[TMR_ONESHOT];
				next_s.tmrRun[ix] = |pwdata[TMR_DLY_W-1:0];
			end
			else if (inBlk(paddr, A_PTR, NPTR))
			begin
				ix = regIdx(paddr, A_PTR);
				next_s.ptrOff[ix[1:0]] = pwdata[PAD_AW-1:0];
				next_s.ptrFixed[ix[1:0]] = pwdata[PTR_FIXED];
			end
			else if (inBlk(paddr, A_PDATA, NPTR))
			begin
				ix = regIdx(paddr, A_PDATA);
				next_s.pad[s.ptrOff[ix[1:0]]] = pwdata[7:0];
				if (!s.ptrFixed[ix[1:0]])
				begin
					next_s.ptrOff[ix[1:0]] = s.ptrOff[ix[1:0]] + 1'b1;
				end
			end
			else if (inBlk(paddr, A_APP, NAPP))
			begin
				ix = regIdx(paddr, A_APP);
				next_s.appGo[ix[1:0]] = 1'b1;
				next_s.appArg = pwdata;
			end
		end

		next_s.upMiniB = (s.upMode == UP_MINIB) ||
			((s.upMode == UP_AUTO) && s.sync2.miniBVbus);

		// Per-channel fault detection; sets win over a clear.
		for (int c = 0; c < NCH; c++)
		begin
			setErr = '0;
			setErr[ERR_OC] = portCurrent[c] > s.iLimit[c];
			if (s.sync2.vbusHigh[c])
			begin
				if (s.bdCnt[c] != BD_LIM)
				begin
					next_s.bdCnt[c] = s.bdCnt[c] + CNT_ONE;
				end
				setErr[ERR_BD] = s.bdCnt[c] == BD_LIM;
			end
			else
			begin
				next_s.bdCnt[c] = '0;
			end
			setErr[ERR_PF] = s.sync2.powerFail[c];
			if (s.vbusEn[c] && !next_s.vbusEn[c])
			begin
				next_s.dcOn[c] = 1'b1;
				next_s.dcCnt[c] = DC_LIM;
			end
			else if (next_s.vbusEn[c])
			begin
				next_s.dcOn[c] = 1'b0;
			end
			else if (s.dcOn[c])
			begin
				next_s.dcCnt[c] = s.dcCnt[c] - CNT_ONE;
				if (s.dcCnt[c] <= CNT_ONE)
				begin
					next_s.dcOn[c] = 1'b0;
					setErr[ERR_PF] = setErr[ERR_PF] | ~s.sync2.vbusLow[c];
				end
			end
			setErr[ERR_DC] = s.dcOn[c];
			next_s.err[c] = next_s.err[c] | setErr;
			if (|(setErr & ~s.err[c]))
			begin
				next_s.irqStat[c] = 1'b1;
			end
		end

		// Timer expiries raise their status bits.
		next_s.irqStat[IRQ_TMR_LSB +: NTMR] =
			next_s.irqStat[IRQ_TMR_LSB +: NTMR] | next_s.tmrFire;
		next_s.irq = |(next_s.irqStat & next_s.irqEn);
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------

	// Registers the state; reset puts automatic upstream mode in place.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s <= '0;
			s.upMode <= UP_AUTO;
		end
		else
		begin
			s <= next_s;
		end
	end

	// Outputs straight from the state flops.
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign vbusEnable = s.vbusEn;
	assign dataEnable = s.dataEn;
	assign dischargeOn = s.dcOn;
	assign upstreamMiniB = s.upMiniB;
	assign timerFire = s.tmrFire;
	assign appTrigger = s.appGo;
	assign appParam = s.appArg;
	assign irq = s.irq;

endmodule : uhp_port_ctrl

// *** verif/uhp_chk_properties.sv ***
`timescale 1ns/1ps

module uhp_chk
	import uhp_pkg::*;
#(
	parameter int unsigned DC_CYCLES = DISCHARGE_CYC
)
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Port switches and handlers.
	input wire logic [NCH-1:0] vbusEnable,
	input wire logic [NCH-1:0] dataEnable,
	input wire logic [NCH-1:0] dischargeOn,
	input wire logic [NAPP-1:0] appTrigger,
	input wire logic [31:0] appParam
);
	// ----------------------------------------------------------------
	// Sequences and helpers
	// ----------------------------------------------------------------
	int unsigned dcCount;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// Counts how long channel 0 has been discharging.
	always_ff @(posedge clk)
	begin
		if (rst || !dischargeOn[0])
			dcCount <= 0;
		else
			dcCount <= dcCount + 1;
	end

	sequence s_take(logic [7:0] a);
		psel && penable && pready && pwrite && paddr == a;
	endsequence

	sequence s_cmd(logic [2:0] op);
		s_take(A_CMD) ##0 pwdata[4:2] == op;
	endsequence

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_pwr_on: assert property (
		s_cmd(3'h0) |=> vbusEnable[$past(pwdata[1:0])])
		else $error("power on command not applied");
	a_pwr_off_discharge: assert property (
		s_cmd(3'h1) ##0 vbusEnable[pwdata[1:0]] |=>
		!vbusEnable[$past(pwdata[1:0])] && dischargeOn[$past(pwdata[1:0])])
		else $error("power off did not start discharge");
	a_data_off: assert property (
		s_cmd(3'h3) |=> !dataEnable[$past(pwdata[1:0])])
		else $error("data off command not applied");
	a_port_on: assert property (
		s_cmd(3'h4) |=> vbusEnable[$past(pwdata[1:0])]
		&& dataEnable[$past(pwdata[1:0])])
		else $error("port on command not applied");
	a_hub_mode_map: assert property (
		s_take(A_HUBMODE) |=> vbusEnable == {$past(pwdata[7]),
		$past(pwdata[5]), $past(pwdata[3]), $past(pwdata[1])}
		&& dataEnable == {$past(pwdata[6]), $past(pwdata[4]),
		$past(pwdata[2]), $past(pwdata[0])})
		else $error("hub mode word not mapped to switches");
	a_app_trigger: assert property (
		psel && penable && pready && pwrite && paddr[7:4] == 4'h9 |=>
		appTrigger == 4'h1 << $past(paddr[3:2])
		&& appParam == $past(pwdata))
		else $error("app write did not trigger with parameter");
	a_ready_first: assert property (
		$rose(penable) && psel |-> pready)
		else $error("pready missing in first access cycle");
	a_bad_addr: assert property (
		psel && penable && pready && paddr == 8'hFC |-> pslverr)
		else $error("unmapped address without error");
	a_rdata_idle: assert property (
		!pready |-> prdata == 32'h0)
		else $error("read data not zero outside access");
	a_discharge_len: assert property (
		dcCount <= DC_CYCLES + 1)
		else $error("discharge window too long");
endmodule : uhp_chk

bind uhp_port_ctrl uhp_chk #(.DC_CYCLES(DC_CYCLES)) u_chk (
	.clk(clk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .vbusEnable(vbusEnable),
	.dataEnable(dataEnable), .dischargeOn(dischargeOn),
	.appTrigger(appTrigger), .appParam(appParam));

// *** verif/uhp_app_model.sv ***
`timescale 1ns/1ps

module uhp_app_model
	import uhp_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Handler requests.
	input wire logic [NAPP-1:0] appTrigger,
	input wire logic [31:0] appParam,
	// Handler answers.
	output logic [NAPP-1:0] appDone,
	output logic [31:0] appResult
);
	// ----------------------------------------------------------------
	// Handler model
	// ----------------------------------------------------------------
	logic [NAPP-1:0] pend;
	logic [31:0] held;
	logic [3:0] delay;

	// parameter in, result out.
	// The answer comes 1 to 8 cycles late, picked by the parameter.
	always @(posedge clk)
	begin
		appDone <= '0;
		appResult <= ~appResult;
		if (rst)
		begin
			pend <= '0;
			delay <= 4'h0;
			appResult <= 32'h5A5A_5A5A;
		end
		else if (|appTrigger)
		begin
			pend <= appTrigger;
			held <= ~appParam;
			delay <= {1'b0, appParam[2:0]};
		end
		else if (pend != '0)
		begin
			if (delay == 4'h0)
			begin
				appDone <= pend;
				appResult <= held;
				pend <= '0;
			end
			else
				delay <= delay - 4'h1;
		end
	end
endmodule : uhp_app_model

// *** verif/tb_top.sv ***
`timescale 1ns/1ps

module tb_top
	import uhp_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals and instances
	// ----------------------------------------------------------------
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, appParam, appResult;
	logic pready, pslverr, upstreamMiniB, irq;
	uhp_pins_t pins = '{vbusLow: '1, default: '0};
	logic [NCH-1:0][ILIM_W-1:0] portCurrent = '0;
	logic [NCH-1:0] vbusEnable, dataEnable, dischargeOn;
	logic [NAPP-1:0] appTrigger, appDone;
	logic [NTMR-1:0] timerFire;
	logic [NCH-1:0] expVb = '0;
	logic [NCH-1:0] expDe = '0;
	logic [3:0] expErr [NCH] = '{default: 4'h0};
	logic [32:0] expQ [$];
	int errTotal = 0;
	int compares = 0;
	int nFire = 0;

	// Makes the 40 MHz clock.
	always #12.5 clk = ~clk;

	uhp_port_ctrl #(.BD_CYCLES(20), .DC_CYCLES(50)) DUT (
		.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pins(pins), .portCurrent(portCurrent),
		.vbusEnable(vbusEnable), .dataEnable(dataEnable),
		.dischargeOn(dischargeOn), .upstreamMiniB(upstreamMiniB),
		.timerFire(timerFire), .appTrigger(appTrigger),
		.appParam(appParam), .appDone(appDone),
		.appResult(appResult), .irq(irq));

	uhp_app_model u_app (.clk(clk), .rst(rst), .appTrigger(appTrigger),
		.appParam(appParam), .appDone(appDone), .appResult(appResult));

	// ----------------------------------------------------------------
	// Checking and bus tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			errTotal++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic report_and_stop;
		if (errTotal == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++)
		begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		if (n == 20)
		begin
			check(32'h0, 32'h1);
			report_and_stop;
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic se = 1'b0);
		expQ.push_back({se, e});
		apb(1'b0, a, 32'h0);
	endtask : rd

	// Takes the oldest note at the edge that completes a read.
	always @(posedge clk)
	begin
		if (psel && penable && pready === 1'b1 && !pwrite)
		begin
			check(prdata, expQ[0][31:0]);
			check(32'(pslverr), 32'(expQ[0][32]));
			void'(expQ.pop_front());
		end
	end

	// Counts expiries of timer 0.
	always @(posedge clk)
	begin
		if (timerFire[0] === 1'b1)
			nFire++;
	end

	function automatic logic [31:0] err_word;
		logic [31:0] w;
		w = 32'h0;
		for (int c = 0; c < NCH; c++)
			w[8*c +: 8] = {4'h0, expErr[c]};
		return w;
	endfunction : err_word

	function automatic logic [31:0] pstate(input int c);
		return {11'h0, pins.boostOn[c], |expErr[c], 17'h0, expDe[c],
			expVb[c]};
	endfunction : pstate

	task automatic set_port(input int c, input logic v, input logic d);
		if (expVb[c] && !v)
			expErr[c][ERR_DC] = 1'b1;
		expVb[c] = v;
		expDe[c] = d;
	endtask : set_port

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		logic [31:0] r;
		int t;
		r = $urandom(95);
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(A_UPMODE, 32'h2);
		rd(A_ERRSTAT, 32'h0);
		r = $urandom();
		pins.boostOn <= r[11:8];
		wr(A_HUBMODE, r);
		for (int c = 0; c < NCH; c++)
			set_port(c, r[2*c+1], r[2*c]);
		rd(A_HUBMODE, {24'h0, r[7:0]});
		check(32'(vbusEnable), 32'(expVb));
		for (int c = 0; c < NCH; c++)
		begin
			for (int op = 0; op < 6; op++)
			begin
				wr(A_CMD, {27'h0, op[2:0], c[1:0]});
				case (op)
					0: set_port(c, 1'b1, expDe[c]);
					1: set_port(c, 1'b0, expDe[c]);
					2: set_port(c, expVb[c], 1'b1);
					3: set_port(c, expVb[c], 1'b0);
					4: set_port(c, 1'b1, 1'b1);
					default: set_port(c, 1'b0, 1'b0);
				endcase
				check(32'({dataEnable, vbusEnable}), 32'({expDe, expVb}));
				rd(A_PSTATE + 8'(4*c), pstate(c));
			end
		end
		wr(A_CMD, {27'h0, 3'h7, 2'h0});
		check(32'({dataEnable, vbusEnable}), 32'({expDe, expVb}));
		repeat (60) @(posedge clk);
		rd(A_ERRSTAT, err_word());
		wr(A_ERRBANK, 32'h1);
		rd(A_ERRSTAT, 32'h0);
		wr(A_ERRBANK, 32'h0);
		rd(A_IRQSTAT, 32'hF);
		wr(A_IRQEN, 32'h1);
		check(32'(irq), 32'h1);
		wr(A_IRQEN, 32'h0);
		check(32'(irq), 32'h0);
		wr(A_IRQCLR, 32'hF);
		rd(A_IRQSTAT, 32'h0);
		wr(A_CMD, {27'h0, 3'h6, 2'h1});
		expErr[1] = 4'h0;
		rd(A_ERRSTAT, err_word());
		wr(A_IRQEN, 32'h2);
		pins.vbusHigh[1] <= 1'b1;
		repeat (10) @(posedge clk);
		pins.vbusHigh[1] <= 1'b0;
		repeat (5) @(posedge clk);
		rd(A_ERRSTAT, err_word());
		pins.vbusHigh[1] <= 1'b1;
		repeat (30) @(posedge clk);
		pins.vbusHigh[1] <= 1'b0;
		expErr[1][ERR_BD] = 1'b1;
		repeat (5) @(posedge clk);
		rd(A_ERRSTAT, err_word());
		check(32'(irq), 32'h1);
		wr(A_ILIMIT, 32'h0040_0000);
		portCurrent[2] <= 8'h40;
		repeat (5) @(posedge clk);
		rd(A_ERRSTAT, err_word());
		portCurrent[2] <= 8'h41;
		expErr[2][ERR_OC] = 1'b1;
		repeat (5) @(posedge clk);
		rd(A_ERRSTAT, err_word());
		wr(A_CMD, {27'h0, 3'h0, 2'h3});
		pins.vbusLow[3] <= 1'b0;
		wr(A_CMD, {27'h0, 3'h1, 2'h3});
		check(32'(dischargeOn[3]), 32'h1);
		repeat (60) @(posedge clk);
		check(32'(dischargeOn[3]), 32'h0);
		expErr[3] = 4'hC;
		rd(A_ERRSTAT, err_word());
		pins.vbusLow[3] <= 1'b1;
		pins.miniBVbus <= 1'b1;
		wr(A_UPMODE, 32'h0);
		rd(A_UPSTATE, 32'h0);
		wr(A_UPMODE, 32'h1);
		rd(A_UPSTATE, 32'h1);
		wr(A_UPMODE, 32'h3);
		rd(A_UPMODE, 32'h1);
		wr(A_UPMODE, 32'h2);
		rd(A_UPSTATE, 32'h1);
		check(32'(upstreamMiniB), 32'h1);
		pins.miniBVbus <= 1'b0;
		repeat (4) @(posedge clk);
		rd(A_UPSTATE, 32'h0);
		check(32'(upstreamMiniB), 32'h0);
		wr(A_TMR, 32'h8000_000A);
		for (t = 0; t < 40 && timerFire[0] !== 1'b1; t++)
			@(negedge clk);
		check(32'(t), 32'h0000_000A);
		repeat (40) @(posedge clk);
		check(nFire, 32'h1);
		// A periodic timer reloads until a zero delay stops it.
		wr(A_TMR, 32'h0000_0005);
		repeat (20) @(posedge clk);
		wr(A_TMR, 32'h0000_0000);
		repeat (10) @(posedge clk);
		check(nFire, 32'h5);
		wr(A_PTR, 32'h105);
		wr(A_PDATA, 32'hAB);
		rd(A_PDATA, 32'hAB);
		rd(A_PDATA, 32'hAB);
		wr(A_PTR + 8'h4, 32'h5);
		rd(A_PDATA + 8'h4, 32'hAB);
		rd(A_PTR + 8'h4, 32'h6);
		r = $urandom();
		wr(A_APP + 8'h4, r);
		check(appParam, r);
		repeat (12) @(posedge clk);
		rd(A_APP + 8'h4, ~r);
		rd(8'hFC, 32'h0, 1'b1);
		repeat (4) @(posedge clk);
		report_and_stop;
	end

	// Cuts a hung run short.
	initial
	begin
		repeat (20000) @(posedge clk);
		check(32'h0, 32'h1);
		report_and_stop;
	end
endmodule : tb_top
